// File: include/oesr_defs.vh
/*
  shared constants of the output enable serial register bank: register
  indices, power-up values, writable masks, field positions and bus address.
  assumes it is included by bare name from the design source file.
*/
`ifndef OESR_DEFS_VH
`define OESR_DEFS_VH

// register indices as chosen command codes
`define OESR_IDX_GROUP_A 8'h00
`define OESR_IDX_GROUP_B 8'h01
`define OESR_IDX_PLL_TEST 8'h02

// power-up values
`define OESR_RST_GROUP_A 8'hFF
`define OESR_RST_GROUP_B 8'hC0
`define OESR_RST_PLL_TEST 8'hC0

// writable masks; reserved bits hold their power-up value
`define OESR_WMASK_GROUP_A 8'hCD
`define OESR_WMASK_GROUP_B 8'h40
`define OESR_WMASK_PLL_TEST 8'h80

// field positions
`define OESR_A_PAIR0 7
`define OESR_A_PAIR1 6
`define OESR_A_PAIR2 3
`define OESR_A_PAIR5 2
`define OESR_A_PAIR4 0
`define OESR_B_PAIR3 6
`define OESR_T_LEAK_N 7

// default 7-bit bus address, chosen
`define OESR_DEV_ADDR 7'h69

`endif

// File: src/oesr_pair_gate.v
/*
  one differential output pair with glitch-free enable.
  assumes ref_clk is the buffered clock sampled in the mclk domain and
  that enable is a level already in the mclk domain.
*/
module oesr_pair_gate (
  input wire mclk,
  input wire srst,
  input wire ref_clk,
  input wire enable,
  output reg true_out,
  output reg comp_out,
  output reg drive_en
);
  // the enable moves only at an edge that also leaves the true output
  // low, so a pair starts or stops on a whole period; a one-cycle lag
  // here would let the enable move just as the true output rises
  always @(posedge mclk) begin
    if (srst) begin
      true_out <= 1'b0;
      comp_out <= 1'b1;
      drive_en <= 1'b1;
    end else begin
      if (!ref_clk) begin
        drive_en <= enable;
      end
      true_out <= ref_clk;
      comp_out <= ~ref_clk;
    end
  end
endmodule // oesr_pair_gate

// File: src/oesr_serial_regs.v
/*
  serial control register bank of a six-pair clock buffer: two-wire
  slave, three registers, per-pair output enables.
  assumes bus pins and the reference clock come from outside mclk,
  and the pads resolve the open-drain data line from its enable.
*/
`include "oesr_defs.vh"
module oesr_serial_regs #(
  parameter [6:0] DEV_ADDR = `OESR_DEV_ADDR
) (
  input wire mclk,
  input wire srst,
  input wire serial_bus_clock,
  input wire serial_bus_data_in,
  output wire serial_bus_data_out,
  output reg serial_bus_data_oe,
  input wire ref_clk,
  output wire [5:0] true_clock_out,
  output wire [5:0] complement_clock_out,
  output wire [5:0] clock_out_en,
  output reg feedback_clock_out,
  output wire pll_leak_test
);
  localparam ST_IDLE = 3'h0; // waiting for start
  localparam ST_ADDR = 3'h1; // address byte
  localparam ST_CMD = 3'h2; // command code byte
  localparam ST_CNT = 3'h3; // byte count byte
  localparam ST_DATA = 3'h4; // data bytes
  localparam ST_SKIP = 3'h5; // not ours, wait for stop

  reg [2:0] scl_sync; // [0] first stage, read by [1] only
  reg [2:0] sda_sync;
  reg [1:0] ref_sync; // reference clock synchroniser
  reg [2:0] state;
  reg [3:0] bit_cnt; // bits shifted this byte
  reg [7:0] shift;
  reg ack_phase; // ninth clock being driven
  reg [7:0] reg_ptr; // current register index
  reg [7:0] group_a;
  reg [7:0] group_b;
  reg [7:0] pll_test;
  reg [7:0] pend_data; // byte waiting for its acknowledge
  reg pend_valid;
  reg is_write;

  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire scl_rise = scl_sync[1] & ~scl_sync[2];
  wire scl_fall = ~scl_sync[1] & scl_sync[2];
  wire start_cond = scl & scl_sync[2] & ~sda & sda_sync[2];
  wire stop_cond = scl & scl_sync[2] & sda & ~sda_sync[2];

  // open-drain: output is always low, enable pulls the line
  assign serial_bus_data_out = 1'b0;

  // merge a written byte with the fixed reserved bits
  function [7:0] oesr_merge;
    input [7:0] wdata;
    input [7:0] mask;
    input [7:0] rst;
    begin
      oesr_merge = (wdata & mask) | (rst & ~mask);
    end
  endfunction

  // two-flop synchronisers, plus one history stage for edges on the two bus lines only
  always @(posedge mclk) begin
    if (srst) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      ref_sync <= 2'h0;
    end else begin
      scl_sync <= {scl_sync[1:0], serial_bus_clock};
      sda_sync <= {sda_sync[1:0], serial_bus_data_in};
      ref_sync <= {ref_sync[0], ref_clk};
    end
  end

  // byte engine: address, command, count, then data bytes
  always @(posedge mclk) begin
    if (srst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ack_phase <= 1'b0;
      serial_bus_data_oe <= 1'b0;
      reg_ptr <= 8'h00;
      group_a <= `OESR_RST_GROUP_A;
      group_b <= `OESR_RST_GROUP_B;
      pll_test <= `OESR_RST_PLL_TEST;
      pend_data <= 8'h00;
      pend_valid <= 1'b0;
      is_write <= 1'b0;
    end else if (start_cond) begin
      // a repeated start restarts the frame
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      serial_bus_data_oe <= 1'b0;
      pend_valid <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      ack_phase <= 1'b0;
      serial_bus_data_oe <= 1'b0;
      pend_valid <= 1'b0;
    end else if (state != ST_IDLE && state != ST_SKIP) begin
      if (scl_rise && !ack_phase) begin
        // sample a data bit while clock is high
        shift <= {shift[6:0], sda};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_fall && ack_phase) begin
        // ninth clock done: release line, commit pending byte
        ack_phase <= 1'b0;
        serial_bus_data_oe <= 1'b0;
        bit_cnt <= 4'h0;
        if (pend_valid && is_write) begin
          pend_valid <= 1'b0;
          reg_ptr <= reg_ptr + 8'h01;
          case (reg_ptr)
            `OESR_IDX_GROUP_A: begin
              group_a <= oesr_merge(pend_data, `OESR_WMASK_GROUP_A,
                `OESR_RST_GROUP_A);
            end
            `OESR_IDX_GROUP_B: begin
              group_b <= oesr_merge(pend_data, `OESR_WMASK_GROUP_B,
                `OESR_RST_GROUP_B);
            end
            `OESR_IDX_PLL_TEST: begin
              pll_test <= oesr_merge(pend_data, `OESR_WMASK_PLL_TEST,
                `OESR_RST_PLL_TEST);
            end
            default: begin
              // unmapped index: byte acknowledged and dropped
            end
          endcase
        end
      end else if (scl_fall && bit_cnt == 4'h8) begin
        // eighth bit ended: decide whether to acknowledge
        case (state)
          ST_ADDR: begin
            if (shift[7:1] == DEV_ADDR && !shift[0]) begin
              is_write <= 1'b1;
              ack_phase <= 1'b1;
              serial_bus_data_oe <= 1'b1;
              state <= ST_CMD;
            end else begin
              // reads are not served; ignore the frame
              is_write <= 1'b0;
              state <= ST_SKIP;
            end
          end
          ST_CMD: begin
            reg_ptr <= shift; // command code picks first register
            ack_phase <= 1'b1;
            serial_bus_data_oe <= 1'b1;
            state <= ST_CNT;
          end
          ST_CNT: begin
            // count byte is acknowledged; frame length set by stop
            ack_phase <= 1'b1;
            serial_bus_data_oe <= 1'b1;
            state <= ST_DATA;
          end
          ST_DATA: begin
            pend_data <= shift;
            pend_valid <= 1'b1;
            ack_phase <= 1'b1;
            serial_bus_data_oe <= 1'b1;
          end
          default: begin
            state <= ST_SKIP;
          end
        endcase
      end
    end
  end

  // feedback output follows the reference with no enable at all
  always @(posedge mclk) begin
    if (srst) begin
      feedback_clock_out <= 1'b0;
    end else begin
      feedback_clock_out <= ref_sync[1];
    end
  end

  assign pll_leak_test = ~pll_test[`OESR_T_LEAK_N];

  // per-pair enable map, in pair order 0..5
  wire [5:0] pair_en = {group_a[`OESR_A_PAIR5], group_a[`OESR_A_PAIR4],
    group_b[`OESR_B_PAIR3], group_a[`OESR_A_PAIR2],
    group_a[`OESR_A_PAIR1], group_a[`OESR_A_PAIR0]};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_pair
      oesr_pair_gate u_gate (
        .mclk(mclk),
        .srst(srst),
        .ref_clk(ref_sync[1]),
        .enable(pair_en[gi]),
        .true_out(true_clock_out[gi]),
        .comp_out(complement_clock_out[gi]),
        .drive_en(clock_out_en[gi])
      );
    end
  endgenerate
endmodule // oesr_serial_regs

// File: verification/oesr_serial_regs_properties.sv
/* port assertions of the serial register bank.
   assumes it is bound to every instance of the top module. */
module oesr_serial_regs_properties (
  input wire mclk,
  input wire srst,
  input wire serial_bus_clock,
  input wire serial_bus_data_in,
  input wire serial_bus_data_out,
  input wire serial_bus_data_oe,
  input wire ref_clk,
  input wire [5:0] true_clock_out,
  input wire [5:0] complement_clock_out,
  input wire [5:0] clock_out_en,
  input wire feedback_clock_out,
  input wire pll_leak_test
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ack stands at least eight system clocks, then lets go within twenty more
  sequence s_ack_hold;
    serial_bus_data_oe [*8] ##[1:20] !serial_bus_data_oe;
  endsequence
  a_ack_held: assert property (
    $rose(serial_bus_data_oe) |-> s_ack_hold)
    else $error("ack not held for one bus clock");
  a_ack_clk_low: assert property (
    $rose(serial_bus_data_oe) |-> !serial_bus_clock)
    else $error("ack raised while bus clock high");
  a_open_drain: assert property (
    serial_bus_data_oe |-> !serial_bus_data_out)
    else $error("data line driven high");
  a_reset_values: assert property (
    $fell(srst) |-> clock_out_en == 6'h3F && !pll_leak_test)
    else $error("wrong power-up outputs");
  a_fb_follows: assert property (
    $rose(ref_clk) |-> ##[1:5] feedback_clock_out)
    else $error("feedback output not following");
  a_pair_inverse: assert property (
    (~clock_out_en | (true_clock_out ^ complement_clock_out)) == 6'h3F)
    else $error("driven pair not complementary");
  // an enable may only move while the true output is low
  a_en_no_runt: assert property (
    ((clock_out_en ^ $past(clock_out_en)) & true_clock_out) == 6'h00)
    else $error("enable changed mid pulse");
  a_en_after_ack: assert property (
    $changed(clock_out_en) |-> !serial_bus_data_oe)
    else $error("enable changed during ack");
  a_leak_after_ack: assert property (
    $changed(pll_leak_test) |-> !serial_bus_data_oe)
    else $error("test flag changed during ack");
endmodule // oesr_serial_regs_properties
bind oesr_serial_regs oesr_serial_regs_properties i_props (.*);

// File: verification/oesr_host_model.sv
/* host of the two-wire bus: write frames only.
   assumes the bench resolves the data wire from both drivers. */
module oesr_host_model (
  input wire mclk,
  input wire bus_wire,
  output reg bus_clk,
  output reg bus_dat
);
  timeunit 1ns;
  timeprecision 100ps;
  // both lines released while idle; bus clock stands still
  initial begin
    bus_clk = 1;
    bus_dat = 1;
  end
  // wait n falling system clock edges
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // one bit, data changed only while bus clock is low
  task automatic clk_bit(input logic v, output logic s);
    bus_dat = v;
    w(5);
    bus_clk = 1;
    w(5);
    s = bus_wire;
    w(5);
    bus_clk = 0;
    w(5);
  endtask
  // a byte msb first, then the ack clock with data released
  task automatic put(input logic [7:0] b, inout int acks);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    if (s === 1'b0) begin
      acks++;
    end
  endtask
  // start, address, command, count, data, stop
  task automatic frame(input logic [6:0] adr, input logic [7:0] cmd,
      input logic [7:0] d0, input logic [7:0] d1, input int n,
      output int acks);
    acks = 0;
    bus_dat = 0;
    w(10);
    bus_clk = 0;
    w(5);
    put({adr, 1'b0}, acks);
    put(cmd, acks);
    put(8'(n), acks);
    put(d0, acks);
    if (n > 1) begin
      put(d1, acks);
    end
    bus_dat = 0;
    w(5);
    bus_clk = 1;
    w(5);
    bus_dat = 1;
    w(20);
  endtask
endmodule // oesr_host_model

// File: verification/oesr_serial_regs_bench.sv
/* self-checking bench: random writes through the host model.
   assumes the checker is bound by its own file. */
module oesr_serial_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, srst = 1, ref_clk = 0;
  wire bclk, bdat, dout, oe, fb, leak;
  wire [5:0] tco, cco, en;
  // open-drain data wire: low if either side pulls
  wire bus_wire = bdat & ~(oe & ~dout);
  int err_total = 0, check_count = 0;
  // expected registers, reserved bits at power-up level
  logic [7:0] ra = 8'hFF, rb = 8'hC0, rt = 8'hC0;
  initial forever #2 mclk = ~mclk;
  // slow reference so every level is sampled
  initial forever #32 ref_clk = ~ref_clk;
  oesr_host_model i_oesr_host_model (.mclk(mclk), .bus_wire(bus_wire),
    .bus_clk(bclk), .bus_dat(bdat));
  oesr_serial_regs i_oesr_serial_regs (.mclk(mclk), .srst(srst),
    .serial_bus_clock(bclk), .serial_bus_data_in(bus_wire),
    .serial_bus_data_out(dout), .serial_bus_data_oe(oe),
    .ref_clk(ref_clk), .true_clock_out(tco),
    .complement_clock_out(cco), .clock_out_en(en),
    .feedback_clock_out(fb), .pll_leak_test(leak));
  // pair enables from the two output registers
  function automatic logic [5:0] exp_en(input logic [7:0] a, b);
    exp_en = {a[2], a[0], b[6], a[3], a[6], a[7]};
  endfunction
  // only documented bits take the written value
  task automatic upd(input logic [7:0] i, input logic [7:0] d);
    case (i)
      8'h00: ra = d | 8'h32;
      8'h01: rb = (d & 8'h40) | 8'h80;
      8'h02: rt = (d & 8'h80) | 8'h40;
      default: ;
    endcase
  endtask
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // first three loop frames disable all pairs and turn the leakage test on; the other 13 loop frames are random
  initial begin
    int acks, n;
    logic [7:0] idx, d0, d1;
    void'($urandom(77));
    repeat (8) @(negedge mclk);
    srst = 0;
    repeat (4) @(negedge mclk);
    chk({leak, en}, 7'h3F);
    i_oesr_host_model.frame(7'h12, 8'h00, 8'h00, 8'h00, 1, acks);
    chk(7'(acks), 7'h00);
    for (int k = 0; k < 16; k++) begin
      idx = (k < 3) ? 8'(k) : 8'($urandom_range(3));
      d0 = (k < 3) ? 8'h00 : 8'($urandom);
      d1 = 8'($urandom);
      n = $urandom_range(2, 1);
      i_oesr_host_model.frame(7'h69, idx, d0, d1, n, acks);
      chk(7'(acks), 7'(n + 3));
      upd(idx, d0);
      if (n > 1) begin
        upd(idx + 8'h01, d1);
      end
      repeat (40) @(negedge mclk);
      chk({leak, en}, {~rt[7], exp_en(ra, rb)});
    end
    // corner: pair 3 off and leakage test on, then a mid-run reset
    i_oesr_host_model.frame(7'h69, 8'h01, 8'h00, 8'h00, 2, acks);
    chk(7'(acks), 7'h05);
    upd(8'h01, 8'h00);
    upd(8'h02, 8'h00);
    repeat (40) @(negedge mclk);
    chk({leak, en}, {~rt[7], exp_en(ra, rb)});
    srst = 1;
    repeat (8) @(negedge mclk);
    srst = 0;
    ra = 8'hFF;
    rb = 8'hC0;
    rt = 8'hC0;
    repeat (4) @(negedge mclk);
    chk({leak, en}, {~rt[7], exp_en(ra, rb)});
    report_and_stop;
  end
  // a hang is cut short well past the expected run
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    $display("FAIL %0t watchdog", $time);
    report_and_stop;
  end
endmodule // oesr_serial_regs_bench
